// ===== hw/adc_config_register_bank.v
// Converter configuration register bank behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "adc_config_map.vh"

// Bus timing seen from the master
// - Write address and write data may come together or apart
// - Each half is held in its own latch until the other arrives
// - The commit happens the cycle after both latches are full
// - The write answer rises at the same edge as the commit
// - A read answers one edge after its address is taken
// - A new read waits until the old answer is taken
// - A new write waits until the old answer is taken
//
// Address map
// - Byte address is the register index times four
// - Address bits 11:10 must be zero, else the slot is unmapped
// - Unmapped writes are dropped and answer with an error
// - Unmapped reads answer with an error; they return zero unless bits 9:2 match a register index, whose value is returned
//
// Register width
// - Every register holds 16 bits in the low half of the word, except the captured reading, which holds TEMP_WIDTH bits
// - Upper data bits and strobes 3:2 are ignored on write
// - Upper read data bits are always zero
//
// Sensor capture
// - The captured reading lives in its own register
// - A capture and a software write in one cycle: capture wins
// - Holding the trigger high does not reload the reading
// - Software must clear and set the trigger again to reload

module adc_config_register_bank #(
  parameter TEMP_WIDTH = 10              // Sensor result width
) (
  input  wire                  sys_clk,
  input  wire                  rst_b,
  // AXI4-Lite write address
  input  wire [11:0]           s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]            s_axi_bresp,
  output wire                  s_axi_bvalid,
  input  wire                  s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0]           s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0]           s_axi_rdata,
  output wire [1:0]            s_axi_rresp,
  output wire                  s_axi_rvalid,
  input  wire                  s_axi_rready,
  // Live temperature sensor result
  input  wire [TEMP_WIDTH-1:0] tempSensorValue,
  // Configuration outputs to the converter core
  output wire                  laneClockSelectFirst,
  output wire [1:0]            averagingInitField,
  output wire [2:0]            averagingOutputClockField,
  output wire                  converterAPowerDown,
  output wire                  converterBPowerDown,
  output wire                  referenceDisable,
  output wire                  internalRefEnable,
  output wire                  singleDataRate,
  output wire                  laneClockSelectSecond,
  output wire [15:0]           chipPowerAveragingInit
);

  // Register storage
  reg [15:0]           tempCtrl_ff;       // Sensor control
  reg [TEMP_WIDTH-1:0] tempReadback_ff;   // Captured sensor result
  reg [15:0]           clkAvgPd_ff;       // Clock, averaging, power-down
  reg [15:0]           refRate_ff;        // Reference and output rate
  reg [15:0]           chipPdAvg_ff;      // Chip power and averaging init
  reg                  loadTrigPrev_ff;   // Previous load-trigger level

  // Bus handshake state
  reg        awHeld_ff;                   // Write address captured
  reg [11:0] awAddr_ff;                   // Captured write address
  reg        wHeld_ff;                    // Write data captured
  reg [31:0] wData_ff;                    // Captured write data
  reg [3:0]  wStrb_ff;                    // Captured strobes
  reg        bValid_ff;                   // Write response pending
  reg [1:0]  bResp_ff;                    // Write response code
  reg        rValid_ff;                   // Read data pending
  reg [31:0] rData_ff;                    // Read data
  reg [1:0]  rResp_ff;                    // Read response code

  wire       doWrite;                     // Both halves present
  wire [7:0] wrIdx;                       // Word index of write
  wire [7:0] rdIdx;                       // Word index of read
  wire       wrHit;                       // Write address mapped
  wire [15:0] wrMask;                     // Byte lane mask
  wire       loadRise;                    // Trigger edge seen
  reg  [15:0] rdWord;                     // Decoded read value
  reg         rdHit;                      // Read address mapped

  // Accept write channels only while no write response is outstanding, reads only while no read response is
  assign s_axi_awready = ~awHeld_ff & ~bValid_ff;
  assign s_axi_wready  = ~wHeld_ff & ~bValid_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_arready = ~rValid_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rdata   = rData_ff;
  assign s_axi_rresp   = rResp_ff;

  assign doWrite = awHeld_ff & wHeld_ff & ~bValid_ff;
  assign wrIdx   = awAddr_ff[9:2];
  assign rdIdx   = s_axi_araddr[9:2];
  assign wrMask  = {{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
  assign wrHit   = (awAddr_ff[11:10] == 2'h0) &&
                   (wrIdx == `IDX_TEMP_CTRL || wrIdx == `IDX_TEMP_READBACK ||
                    wrIdx == `IDX_CLK_AVG_PD || wrIdx == `IDX_REF_RATE ||
                    wrIdx == `IDX_CHIP_PD_AVG);

  // Collect write address and data in either order
  // Each half is taken only while its latch is empty
  // and no answer is waiting, so a slow master that
  // leaves the answer unread stalls further writes.
  // The commit clears both latches in one step, so a
  // new address cannot land in the same cycle.
  // The answer code is chosen at commit time from the
  // latched address, never from the live bus.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 12'h000;
      wHeld_ff  <= 1'b0;
      wData_ff  <= 32'h00000000;
      wStrb_ff  <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      // Both halves in: commit and answer
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bValid_ff && s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
    end
  end

  // Trigger edge: low last cycle, high now
  assign loadRise = tempCtrl_ff[`TEMP_LOAD_BIT] & ~loadTrigPrev_ff;

  // Register writes and sensor capture
  // Writes merge new bytes under the strobe mask with
  // the bytes already held, so a one-byte write leaves
  // the other byte alone.
  // The trigger history follows the stored control bit,
  // so the edge is seen one cycle after the write lands.
  // Reserved bits are stored as written; keeping them
  // zero is up to software.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tempCtrl_ff     <= `REG_RESET;
      tempReadback_ff <= {TEMP_WIDTH{1'b0}};
      clkAvgPd_ff     <= `REG_RESET;
      refRate_ff      <= `REG_RESET;
      chipPdAvg_ff    <= `REG_RESET;
      loadTrigPrev_ff <= 1'b0;
    end else begin
      loadTrigPrev_ff <= tempCtrl_ff[`TEMP_LOAD_BIT];
      if (doWrite && wrIdx == `IDX_TEMP_CTRL && wrHit) begin
        tempCtrl_ff <= (tempCtrl_ff & ~wrMask) | (wData_ff[15:0] & wrMask);
      end
      if (doWrite && wrIdx == `IDX_CLK_AVG_PD && wrHit) begin
        clkAvgPd_ff <= (clkAvgPd_ff & ~wrMask) | (wData_ff[15:0] & wrMask);
      end
      if (doWrite && wrIdx == `IDX_REF_RATE && wrHit) begin
        refRate_ff <= (refRate_ff & ~wrMask) | (wData_ff[15:0] & wrMask);
      end
      if (doWrite && wrIdx == `IDX_CHIP_PD_AVG && wrHit) begin
        chipPdAvg_ff <= (chipPdAvg_ff & ~wrMask) |
                        (wData_ff[15:0] & wrMask);
      end
      // capture reading; only on rising edge, wins over write
      if (loadRise) begin
        tempReadback_ff <= tempSensorValue;
      end else if (doWrite && wrIdx == `IDX_TEMP_READBACK && wrHit) begin
        tempReadback_ff <= (tempReadback_ff & ~wrMask[TEMP_WIDTH-1:0]) |
                           (wData_ff[TEMP_WIDTH-1:0] &
                            wrMask[TEMP_WIDTH-1:0]);
      end
    end
  end

  // Read decode
  // Pure decode of the live read address into a word
  // and a hit flag; the flops below take the result.
  // Indices with no register fall through to zero and a miss.
  always @* begin
    rdWord = 16'h0000;
    rdHit  = (s_axi_araddr[11:10] == 2'h0);
    case (rdIdx)
      `IDX_TEMP_CTRL:     rdWord = tempCtrl_ff;
      // 10-bit result, upper bits read zero
      `IDX_TEMP_READBACK: rdWord = {{(16-TEMP_WIDTH){1'b0}},
                                    tempReadback_ff};
      `IDX_CLK_AVG_PD:    rdWord = clkAvgPd_ff;
      `IDX_REF_RATE:      rdWord = refRate_ff;
      `IDX_CHIP_PD_AVG:   rdWord = chipPdAvg_ff;
      default:            rdHit  = 1'b0;
    endcase
  end

  // Read channel: answer one cycle after address taken
  // Data and code are frozen while the answer waits,
  // so a master that reads late still sees the value
  // from the moment its address was taken.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rValid_ff <= 1'b0;
      rData_ff  <= 32'h00000000;
      rResp_ff  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_ff <= 1'b1;
      rData_ff  <= {16'h0000, rdWord};
      rResp_ff  <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rValid_ff && s_axi_rready) begin
      rValid_ff <= 1'b0;
    end
  end

  // Configuration outputs
  // Every output but internalRefEnable is a plain slice of a stored register,
  // so the converter core sees flop outputs apart from that one inverter.
  // The reference pair is one bit and its inverse, so
  // the two can never disagree.
  // clock configuration for lane settings
  assign laneClockSelectFirst = clkAvgPd_ff[`LANE_LANE_CLOCK_SELECT_FIRST_BIT];
  assign averagingInitField =
    clkAvgPd_ff[`AVG_INIT_MSB:`AVG_INIT_LSB];
  assign averagingOutputClockField =
    clkAvgPd_ff[`AVG_OCLK_MSB:`AVG_OCLK_LSB];
  assign converterAPowerDown = clkAvgPd_ff[`CHAN_PD_LSB];
  assign converterBPowerDown = clkAvgPd_ff[`CHAN_PD_MSB];
  assign referenceDisable  = refRate_ff[`REF_DIS_BIT];
  assign internalRefEnable = ~refRate_ff[`REF_DIS_BIT];
  assign singleDataRate = refRate_ff[`RATE_SDR_BIT];
  assign laneClockSelectSecond = refRate_ff[`LANE_LANE_CLOCK_SELECT_SECOND_BIT];
  assign chipPowerAveragingInit = chipPdAvg_ff;

endmodule

// ===== hw/adc_config_map.vh
// Offsets, field positions, reset values for the converter config bank
`ifndef ADC_CONFIG_MAP_VH
`define ADC_CONFIG_MAP_VH

// Printed offsets (register indices); byte address is index times four
`define IDX_TEMP_CTRL      8'h90
`define IDX_TEMP_READBACK  8'h91
`define IDX_CLK_AVG_PD     8'hC0
`define IDX_REF_RATE       8'hC1
`define IDX_CHIP_PD_AVG    8'hC4

// Field positions
`define TEMP_LOAD_BIT      14
`define TEMP_MSB           9
`define LANE_LANE_CLOCK_SELECT_FIRST_BIT      12
`define AVG_INIT_MSB       11
`define AVG_INIT_LSB       10
`define AVG_OCLK_MSB       9
`define AVG_OCLK_LSB       7
`define CHAN_PD_MSB        1
`define CHAN_PD_LSB        0
`define REF_DIS_BIT        11
`define RATE_SDR_BIT       8
`define LANE_LANE_CLOCK_SELECT_SECOND_BIT      0

// Reset value for every register
`define REG_RESET          16'h0000

// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== verification/adc_config_bank_sva.sv
// Bus handshake and field checks for the converter configuration bank
`timescale 1ns/1ps
module adc_config_bank_sva (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        referenceDisable,
  input wire logic        internalRefEnable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Address and data taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  a_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
  a_bresp_clear: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not cleared");
  a_rresp_clear: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not cleared");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_ref_select: assert property (referenceDisable ^ internalRefEnable)
    else $error("reference selects disagree");
endmodule
bind adc_config_register_bank adc_config_bank_sva adc_config_bank_sva_i (.*);

// ===== verification/adc_config_register_bank_test.sv
// Self-checking bench for the converter configuration bank
`timescale 1ns/1ps
module adc_config_register_bank_test;
  logic sys_clk = 0, rst_b = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic [9:0] tempSensorValue = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, averagingInitField;
  wire [31:0] s_axi_rdata;
  wire [2:0] averagingOutputClockField;
  wire laneClockSelectFirst, converterAPowerDown, converterBPowerDown;
  wire referenceDisable, internalRefEnable, singleDataRate;
  wire laneClockSelectSecond;
  wire [15:0] chipPowerAveragingInit;
  integer mismatches = 0, cmp_count = 0;
  adc_config_register_bank adc_config_register_bank_i (.*);
  always #20 sys_clk = ~sys_clk;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    integer n; bit ad, wd;
    begin
      ad = 0; wd = 0; n = 0;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      do begin
        @(posedge sys_clk); n++;
        if (s_axi_awready && !ad) begin ad = 1; s_axi_awvalid <= 0; end
        if (s_axi_wready && !wd) begin wd = 1; s_axi_wvalid <= 0; end
      end while (!s_axi_bvalid && n < 50);
      if (!s_axi_bvalid) begin
        mismatches++;
        $display("BAD bvalid exp 1 got 0");
      end
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    end
  endtask
  task rd(input [11:0] a, input [31:0] e, input [1:0] er);
    integer n; bit ad;
    begin
      ad = 0; n = 0; s_axi_araddr <= a; s_axi_arvalid <= 1;
      do begin
        @(posedge sys_clk); n++;
        if (s_axi_arready && !ad) begin ad = 1; s_axi_arvalid <= 0; end
      end while (!s_axi_rvalid && n < 50);
      if (!s_axi_rvalid) begin
        mismatches++;
        $display("BAD rvalid exp 1 got 0");
      end
      chk("rdata", e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    end
  endtask
  task t_reset;
    logic [11:0] al [5] = '{12'h240, 12'h244, 12'h300, 12'h304, 12'h310};
    foreach (al[i]) rd(al[i], 32'h0, 2'h0);
    chk("refen", 32'h1, {31'h0, internalRefEnable});
  endtask
  task t_c0;
    for (int p = 0; p < 4; p++) begin
      wr(12'h300, 32'h1680 | p, 2'h0);
      chk("c0out", 32'h1680 | p,
          {19'h0, laneClockSelectFirst, averagingInitField,
           averagingOutputClockField, 5'h0, converterBPowerDown,
           converterAPowerDown});
      rd(12'h300, 32'h1680 | p, 2'h0);
    end
  endtask
  task t_c1;
    logic [31:0] dl [3] = '{32'h0800, 32'h0100, 32'h0001};
    foreach (dl[i]) begin
      wr(12'h304, dl[i], 2'h0);
      chk("c1out",
          {28'h0, dl[i][11], !dl[i][11], dl[i][8], dl[i][0]},
          {28'h0, referenceDisable, internalRefEnable, singleDataRate,
           laneClockSelectSecond});
    end
  endtask
  task t_temp;
    tempSensorValue <= 10'h2A5;
    wr(12'h240, 32'h4000, 2'h0);
    rd(12'h244, 32'h02A5, 2'h0);
    tempSensorValue <= 10'h15A;
    wr(12'h240, 32'h4000, 2'h0);
    rd(12'h244, 32'h02A5, 2'h0);
    wr(12'h240, 32'h0, 2'h0);
    wr(12'h240, 32'h4000, 2'h0);
    rd(12'h244, 32'h015A, 2'h0);
  endtask
  task t_misc;
    wr(12'h400, 32'h1234, 2'h2);
    rd(12'h400, 32'h0, 2'h2);
    wr(12'h310, 32'h0031, 2'h0);
    rd(12'h310, 32'h0031, 2'h0);
    chk("c4out", 32'h31, {16'h0, chipPowerAveragingInit});
    wr(12'h244, 32'hFFFF, 2'h0);
    rd(12'h244, 32'h03FF, 2'h0);
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1;
    t_reset; t_c0; t_c1; t_temp; t_misc;
    end_sim;
  end
endmodule
